// >>> shared/eprom_port_pkg.sv
// shared constants and types of the code-memory programming port
package eprom_port_pkg;
  // ************************************************************
  // clocks and derived timing
  // ************************************************************
  localparam int unsigned CLOCK_PERIOD_NS = 50; // 20 MHz system clock
  localparam int unsigned OSC_SLOW_PERIOD_NS = 250; // slowest legal oscillator, 4 MHz
  localparam int unsigned STROBE_OSC_PERIODS = 48; // setup, hold and access in periods
  localparam int unsigned STROBE_MARGIN_NS = STROBE_OSC_PERIODS * OSC_SLOW_PERIOD_NS;
  localparam int unsigned STROBE_MARGIN_CYCLES =
    (STROBE_MARGIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS; // least time, round up
  localparam int unsigned HV_GUARD_US = 10; // high voltage around the pulse
  localparam int unsigned HV_GUARD_CYCLES =
    (HV_GUARD_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned PULSE_NOMINAL_MS = 50; // write pulse, legal 45 to 55 ms
  localparam int unsigned PULSE_NOMINAL_CYCLES =
    PULSE_NOMINAL_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int unsigned TIMER_W = 21; // holds the longest pulse count
  // ************************************************************
  // pin layout
  // ************************************************************
  localparam int unsigned ADDR_W = 12; // 4K code bytes
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LOW_ADDR_W = 8; // low byte on the address port
  localparam int unsigned UPPER_ENABLE_BIT = 7; // enable / read strobe, active low
  localparam int unsigned UPPER_MODE_BIT = 6; // high selects the lock bit
  localparam int unsigned UPPER_ADDR_MSB = 3; // bits 3..0 carry address high
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // level on the external-access / high-voltage pin
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_HV = 2'h2
  } access_level_t;
  // ************************************************************
  // programmer register port
  // ************************************************************
  localparam int unsigned REG_ADDR_W = 4;
  localparam int unsigned REG_DATA_W = 16;
  localparam logic [3:0] REG_TARGET = 4'h0; // code address
  localparam logic [3:0] REG_BYTE = 4'h1; // byte to write
  localparam logic [3:0] REG_COMMAND = 4'h2; // write starts a command
  localparam logic [3:0] REG_STATUS = 4'h3; // read only
  localparam logic [1:0] CMD_PROGRAM = 2'h1;
  localparam logic [1:0] CMD_VERIFY = 2'h2;
  localparam logic [1:0] CMD_LOCK = 2'h3;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_MISMATCH = 2;
  localparam int unsigned ST_READ_LSB = 8; // last byte read back
endpackage

// >>> shared/eprom_port_if.sv
// pins between the external programmer and the code-memory device
`timescale 1ns/10ps
interface eprom_port_if;
  logic reset_pin; // device reset, high while programming
  logic program_fetch_strobe_n; // held low in all modes
  logic program_pulse_strobe_n; // write pulse, active low
  eprom_port_pkg::access_level_t external_access_hv_pin;
  logic [7:0] addr_low_port; // low address byte
  logic [7:0] upper_port; // address high, mode and enable
  logic [7:0] write_pulse_data_out; // data port, programmer side
  logic [7:0] write_pulse_data_oe;
  logic [7:0] dev_data_out; // data port, device side (drives low only)
  logic [7:0] dev_data_oe;
  logic [7:0] data_port; // resolved level
  // external pull-ups: a bit reads low only where somebody sinks it
  assign data_port = ~((write_pulse_data_oe & ~write_pulse_data_out) | (dev_data_oe & ~dev_data_out));
  modport device (
    input reset_pin, program_fetch_strobe_n, program_pulse_strobe_n,
    input external_access_hv_pin, addr_low_port, upper_port, data_port,
    output dev_data_out, dev_data_oe
  );
  modport programmer (
    output reset_pin, program_fetch_strobe_n, program_pulse_strobe_n,
    output external_access_hv_pin, addr_low_port, upper_port,
    output write_pulse_data_out, write_pulse_data_oe,
    input data_port
  );
endinterface

// >>> verilog/phase_timer.sv
// down-counter that times each phase of a programming sequence
`timescale 1ns/10ps
module phase_timer #(
  parameter int unsigned WIDTH = eprom_port_pkg::TIMER_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic expired
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] count; // cycles left in the phase
  } timer_state_t;
  timer_state_t q;
  timer_state_t next_q;
  // expired n cycles after a load of n
  always_comb begin
    next_q = q;
    if (load) begin
      next_q.count = load_value;
    end else if (q.count != '0) begin
      next_q.count = q.count - WIDTH'(1);
    end
  end
  // register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign expired = (q.count == '0);
endmodule

// >>> verilog/eprom_programmer.sv
// external programmer end: drives modes, address, data and strobes
`timescale 1ns/10ps
// Behaviour
// R1: programmer keeps device clocked at 4-6 MHz; the device shares the 20 MHz system clock here
// R2: address on low and upper ports, data port
// R3: program levels: reset high, fetch low, high voltage
// R4: write pulse low 45 to 55 ms
// R5: high voltage only just around the pulse
// R6: 10 us voltage guards, 48 periods after enable
// R7: address/data stable 48 periods around pulse
// R8: device drives addressed byte in verify mode
// R9: enable bit reads, data port pulled up
// R10: read data valid/float within 48 periods
// R11: lock bit set with mode bit high
// R12: locked device refuses read and programming
// R13: only erasure clears the lock bit; the device reset_n also clears it here
// R14: erased bytes read as all ones
// R15: verify each byte after its pulse
module eprom_programmer #(
  parameter int unsigned PULSE_CYCLES = eprom_port_pkg::PULSE_NOMINAL_CYCLES,
  parameter int unsigned TIMER_W = eprom_port_pkg::TIMER_W
) (
  input wire logic clock,
  input wire logic reset_n,
  eprom_port_if.programmer pins,
  input wire logic [eprom_port_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [eprom_port_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [eprom_port_pkg::REG_DATA_W-1:0] reg_rdata
);
  // ************************************************************
  // types and state
  // ************************************************************
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, // waiting for a command
    S_SETUP = 7'h02, // address, data, enable settle
    S_RAISE = 7'h04, // high voltage before the pulse
    S_PULSE = 7'h08, // write pulse low
    S_LOWER = 7'h10, // high voltage after the pulse
    S_HOLD = 7'h20, // address and data held
    S_READ = 7'h40 // read-back through the enable
  } phase_t;
  typedef struct packed {
    phase_t phase;
    logic [1:0] cmd; // command in progress
    logic [eprom_port_pkg::ADDR_W-1:0] target; // code address
    logic [eprom_port_pkg::DATA_W-1:0] wbyte; // byte to write
    logic done; // sticky, cleared by the next command
    logic mismatch; // program read-back differed from wbyte
    logic [eprom_port_pkg::DATA_W-1:0] rbyte; // last byte read back
    logic [eprom_port_pkg::REG_DATA_W-1:0] rdata; // register read data
    logic rst_pin;
    logic fetch_n;
    logic pulse_n;
    eprom_port_pkg::access_level_t hv;
    logic [7:0] low_port;
    logic [7:0] upper;
    logic [7:0] data_out;
    logic [7:0] data_oe;
  } write_pulse_state_t;
  write_pulse_state_t q;
  write_pulse_state_t next_q;
  logic timer_load; // restarts the phase timer
  logic [TIMER_W-1:0] timer_value;
  logic timer_expired;
  logic [eprom_port_pkg::REG_DATA_W-1:0] status_word;
  // ************************************************************
  // phase timer
  // ************************************************************
  phase_timer #(
    .WIDTH(TIMER_W)
  ) timer (
    .clock(clock),
    .reset_n(reset_n),
    .load(timer_load),
    .load_value(timer_value),
    .expired(timer_expired)
  );
  // ************************************************************
  // status word
  // ************************************************************
  always_comb begin
    status_word = '0;
    status_word[eprom_port_pkg::ST_BUSY] = (q.phase != S_IDLE);
    status_word[eprom_port_pkg::ST_DONE] = q.done;
    status_word[eprom_port_pkg::ST_MISMATCH] = q.mismatch;
    status_word[eprom_port_pkg::ST_READ_LSB +: eprom_port_pkg::DATA_W] = q.rbyte;
  end
  // ************************************************************
  // sequencer and register port
  // ************************************************************
  // the setup, hold and read phases assume the slowest legal oscillator, so any
  // device clock from 4 to 6 MHz is served [R1]
  always_comb begin
    next_q = q;
    timer_load = 1'b0;
    timer_value = '0;
    // register reads answer one cycle later, unmapped read as zero
    next_q.rdata = '0;
    if (reg_read) begin
      unique case (reg_addr)
        eprom_port_pkg::REG_TARGET: next_q.rdata = eprom_port_pkg::REG_DATA_W'(q.target);
        eprom_port_pkg::REG_BYTE: next_q.rdata = eprom_port_pkg::REG_DATA_W'(q.wbyte);
        eprom_port_pkg::REG_STATUS: next_q.rdata = status_word;
        default: next_q.rdata = '0;
      endcase
    end
    // address and byte are frozen while a command runs, so the
    // pins cannot move inside a setup or hold window [R7]
    if (reg_write && q.phase == S_IDLE) begin
      if (reg_addr == eprom_port_pkg::REG_TARGET) begin
        next_q.target = reg_wdata[eprom_port_pkg::ADDR_W-1:0];
      end
      if (reg_addr == eprom_port_pkg::REG_BYTE) begin
        next_q.wbyte = reg_wdata[eprom_port_pkg::DATA_W-1:0];
      end
    end
    unique case (q.phase)
      S_IDLE: begin
        // commands while busy, or code zero, are ignored
        if (reg_write && reg_addr == eprom_port_pkg::REG_COMMAND
            && reg_wdata[1:0] != 2'h0) begin
          next_q.cmd = reg_wdata[1:0];
          next_q.done = 1'b0;
          next_q.mismatch = 1'b0;
          next_q.low_port = q.target[eprom_port_pkg::LOW_ADDR_W-1:0]; // [R2]
          next_q.upper = '0;
          next_q.upper[eprom_port_pkg::UPPER_ADDR_MSB:0] =
            q.target[eprom_port_pkg::ADDR_W-1:eprom_port_pkg::LOW_ADDR_W]; // [R2]
          timer_load = 1'b1;
          timer_value = TIMER_W'(eprom_port_pkg::STROBE_MARGIN_CYCLES);
          if (reg_wdata[1:0] == eprom_port_pkg::CMD_VERIFY) begin
            // enable low starts the read at once [R9]
            next_q.phase = S_READ;
          end else begin
            // enable high, mode bit picks byte or lock bit [R3] [R11]
            next_q.upper[eprom_port_pkg::UPPER_ENABLE_BIT] = 1'b1;
            next_q.upper[eprom_port_pkg::UPPER_MODE_BIT] =
              (reg_wdata[1:0] == eprom_port_pkg::CMD_LOCK); // [R11]
            next_q.data_out = q.wbyte; // [R2]
            next_q.data_oe = '1;
            next_q.phase = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        // 48 periods after enable and data, raise the voltage [R6] [R7]
        if (timer_expired) begin
          next_q.hv = eprom_port_pkg::LVL_HV; // [R5]
          timer_load = 1'b1;
          timer_value = TIMER_W'(eprom_port_pkg::HV_GUARD_CYCLES);
          next_q.phase = S_RAISE;
        end
      end
      S_RAISE: begin
        // voltage settled for 10 us, fire the pulse [R6]
        if (timer_expired) begin
          next_q.pulse_n = 1'b0; // [R4]
          timer_load = 1'b1;
          timer_value = TIMER_W'(PULSE_CYCLES);
          next_q.phase = S_PULSE;
        end
      end
      S_PULSE: begin
        // nominal width, inside the legal window [R4]
        if (timer_expired) begin
          next_q.pulse_n = 1'b1;
          timer_load = 1'b1;
          timer_value = TIMER_W'(eprom_port_pkg::HV_GUARD_CYCLES);
          next_q.phase = S_LOWER;
        end
      end
      S_LOWER: begin
        // voltage held 10 us after the pulse, then back to high [R5] [R6]
        if (timer_expired) begin
          next_q.hv = eprom_port_pkg::LVL_HIGH;
          timer_load = 1'b1;
          timer_value = TIMER_W'(eprom_port_pkg::STROBE_MARGIN_CYCLES);
          next_q.phase = S_HOLD;
        end
      end
      S_HOLD: begin
        // address and data held 48 periods after the pulse [R7]
        if (timer_expired) begin
          next_q.data_oe = '0;
          next_q.upper[eprom_port_pkg::UPPER_MODE_BIT] = 1'b0;
          if (q.cmd == eprom_port_pkg::CMD_LOCK) begin
            // the lock bit cannot be read back; finish here
            next_q.done = 1'b1;
            next_q.phase = S_IDLE;
          end else begin
            // read the byte back before the next address [R15]
            next_q.upper[eprom_port_pkg::UPPER_ENABLE_BIT] = 1'b0; // [R9]
            timer_load = 1'b1;
            timer_value = TIMER_W'(eprom_port_pkg::STROBE_MARGIN_CYCLES);
            next_q.phase = S_READ;
          end
        end
      end
      S_READ: begin
        // sample after the longest access time, port released [R9] [R10]
        if (timer_expired) begin
          next_q.rbyte = pins.data_port;
          next_q.mismatch = (q.cmd == eprom_port_pkg::CMD_PROGRAM)
            && (pins.data_port != q.wbyte); // [R15]
          next_q.done = 1'b1;
          next_q.upper[eprom_port_pkg::UPPER_ENABLE_BIT] = 1'b1; // park off
          next_q.phase = S_IDLE;
        end
      end
      default: begin
        next_q.phase = S_IDLE;
      end
    endcase
  end
  // register; parked with reset high, fetch low, enable high and
  // normal voltage, which is neither program nor verify [R3] [R5]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.phase <= S_IDLE;
      q.rst_pin <= 1'b1;
      q.fetch_n <= 1'b0;
      q.pulse_n <= 1'b1;
      q.hv <= eprom_port_pkg::LVL_HIGH;
      q.upper <= 8'h80;
    end else begin
      q <= next_q;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign pins.reset_pin = q.rst_pin; // [R3]
  assign pins.program_fetch_strobe_n = q.fetch_n; // [R3]
  assign pins.program_pulse_strobe_n = q.pulse_n;
  assign pins.external_access_hv_pin = q.hv;
  assign pins.addr_low_port = q.low_port;
  assign pins.upper_port = q.upper;
  assign pins.write_pulse_data_out = q.data_out;
  assign pins.write_pulse_data_oe = q.data_oe;
  assign reg_rdata = q.rdata;
endmodule

// >>> verilog/eprom_target.sv
// device end: code array, program decode, verify readout and lock bit
`timescale 1ns/10ps
module eprom_target #(
  parameter int unsigned DEPTH = 1 << eprom_port_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic reset_n,
  eprom_port_if.device pins,
  input wire logic uv_erase, // pulse: start a full erasure
  output logic erase_busy, // erasure sweep running
  output logic secured, // lock bit programmed
  output logic external_fetch_allowed // low while locked
);
  localparam int unsigned AW = eprom_port_pkg::ADDR_W;
  localparam int unsigned DW = eprom_port_pkg::DATA_W;
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic secured; // lock bit
    logic erasing; // sweep in progress
    logic [AW-1:0] sweep; // next byte to erase
    logic strobe_low; // pulse pin low last cycle
    logic armed; // a valid pulse is in progress
    logic lock_pulse; // the pulse targets the lock bit
    logic [AW-1:0] wr_addr; // latched at the falling edge
    logic [DW-1:0] wr_byte;
    logic [DW-1:0] rd_byte; // addressed byte
    logic [DW-1:0] pull_low; // data bits sunk on the port
  } dev_state_t;
  dev_state_t q;
  dev_state_t next_q;
  logic [DW-1:0] code_mem [0:DEPTH-1]; // no reset: nonvolatile
  logic [AW-1:0] pin_addr;
  logic program_mode;
  logic verify_mode;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [DW-1:0] mem_wd;
  // ************************************************************
  // mode decode
  // ************************************************************
  always_comb begin
    pin_addr = {pins.upper_port[eprom_port_pkg::UPPER_ADDR_MSB:0],
                pins.addr_low_port}; // [R2]
    program_mode = pins.reset_pin && !pins.program_fetch_strobe_n
      && pins.external_access_hv_pin == eprom_port_pkg::LVL_HV
      && pins.upper_port[eprom_port_pkg::UPPER_ENABLE_BIT];
    verify_mode = pins.reset_pin && !pins.program_fetch_strobe_n
      && pins.program_pulse_strobe_n
      && pins.external_access_hv_pin == eprom_port_pkg::LVL_HIGH
      && !pins.upper_port[eprom_port_pkg::UPPER_ENABLE_BIT]
      && !pins.upper_port[eprom_port_pkg::UPPER_MODE_BIT]; // [R8] [R9]
  end
  // ************************************************************
  // next state and array write
  // ************************************************************
  always_comb begin
    next_q = q;
    mem_we = 1'b0;
    mem_wa = q.wr_addr;
    mem_wd = q.wr_byte & code_mem[q.wr_addr]; // programming only clears bits
    next_q.strobe_low = !pins.program_pulse_strobe_n;
    if (q.erasing) begin
      // sweep the array back to ones, then drop the lock [R13] [R14]
      mem_we = 1'b1;
      mem_wa = q.sweep;
      mem_wd = eprom_port_pkg::ERASED_BYTE; // [R14]
      next_q.sweep = q.sweep + AW'(1);
      if (q.sweep == AW'(DEPTH - 1)) begin
        next_q.erasing = 1'b0;
        next_q.secured = 1'b0; // [R13]
      end
    end else if (uv_erase) begin
      next_q.erasing = 1'b1;
      next_q.sweep = '0;
      next_q.armed = 1'b0;
    end else if (!q.strobe_low && !pins.program_pulse_strobe_n) begin
      // falling edge: latch target, refused while locked [R12]
      next_q.armed = program_mode && !q.secured;
      next_q.lock_pulse = pins.upper_port[eprom_port_pkg::UPPER_MODE_BIT]; // [R11]
      next_q.wr_addr = pin_addr;
      next_q.wr_byte = pins.data_port;
    end else if (q.strobe_low && (pins.program_pulse_strobe_n || !program_mode)) begin
      // voltage or mode lost, or rising edge: the pulse ends here
      next_q.armed = 1'b0;
      if (q.armed && pins.program_pulse_strobe_n && program_mode) begin
        if (q.lock_pulse) begin
          next_q.secured = 1'b1; // [R11]
        end else begin
          mem_we = 1'b1;
        end
      end
    end
    // readout, two cycles from address, one from enable, floats in one [R10]
    next_q.rd_byte = code_mem[pin_addr];
    if (verify_mode && !q.secured && !q.erasing) begin
      next_q.pull_low = ~q.rd_byte; // [R8]
    end else begin
      next_q.pull_low = '0; // locked: port stays released [R12]
    end
  end
  // array write port
  always_ff @(posedge clock) begin
    if (mem_we) begin
      code_mem[mem_wa] <= mem_wd;
    end
  end
  // register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign pins.dev_data_out = '0; // open drain: only sinks [R9]
  assign pins.dev_data_oe = q.pull_low;
  assign erase_busy = q.erasing;
  assign secured = q.secured;
  assign external_fetch_allowed = !q.secured; // [R12]
endmodule

// >>> verification/eprom_port_assertions.sv
// checker on the pins between the programmer end and the device end
`timescale 1ns/10ps
module eprom_port_assertions (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reset_pin,
  input wire logic program_fetch_strobe_n,
  input wire logic program_pulse_strobe_n,
  input wire eprom_port_pkg::access_level_t external_access_hv_pin,
  input wire logic [7:0] addr_low_port,
  input wire logic [7:0] upper_port,
  input wire logic [7:0] data_port,
  input wire logic [7:0] dev_data_oe
);
  // ************************************************************
  // run-length helpers
  // ************************************************************
  localparam int HV_MIN = 200; // 10 us at 20 MHz
  localparam int HOLD_MIN = 240; // 48 periods of the slowest oscillator
  logic hv; // programming voltage on the pin
  logic vmode; // all pins at verify levels
  int hv_cnt; // cycles with programming voltage
  int st_cnt; // cycles with address and data unchanged
  int en_cnt; // cycles with the enable bit high
  int rise_cnt; // cycles since the write pulse ended
  assign hv = external_access_hv_pin == eprom_port_pkg::LVL_HV;
  assign vmode = reset_pin && !program_fetch_strobe_n && program_pulse_strobe_n &&
    external_access_hv_pin == eprom_port_pkg::LVL_HIGH && upper_port[7:6] == 2'h0;
  // counters restart on any change; reset parks rise_cnt far from any pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hv_cnt <= 0;
      st_cnt <= 0;
      en_cnt <= 0;
      rise_cnt <= 32'h000F0000;
    end else begin
      hv_cnt <= hv ? hv_cnt + 1 : 0;
      st_cnt <= $stable({addr_low_port, upper_port, data_port}) ? st_cnt + 1 : 0;
      en_cnt <= upper_port[7] ? en_cnt + 1 : 0;
      rise_cnt <= program_pulse_strobe_n ? rise_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // ************************************************************
  // pin rules
  // ************************************************************
  a_fetch_held_low: assert property (
    !program_fetch_strobe_n) else $error("fetch strobe left its low level");
  a_pulse_in_mode: assert property (
    !program_pulse_strobe_n |-> hv && upper_port[7] && reset_pin)
    else $error("write pulse outside program levels");
  a_hv_setup: assert property (
    $fell(program_pulse_strobe_n) |-> hv_cnt >= HV_MIN) else $error("voltage setup short");
  a_hv_hold: assert property (
    program_pulse_strobe_n && rise_cnt < HV_MIN |-> hv) else $error("voltage hold short");
  a_addr_setup: assert property (
    $fell(program_pulse_strobe_n) |-> st_cnt >= HOLD_MIN) else $error("address setup short");
  a_addr_hold: assert property (
    program_pulse_strobe_n && rise_cnt < HOLD_MIN |->
    $stable({addr_low_port, upper_port, data_port})) else $error("address hold short");
  a_enable_first: assert property (
    $rose(hv) |-> en_cnt >= HOLD_MIN) else $error("voltage too soon after enable");
  a_verify_only: assert property (
    dev_data_oe != 8'h00 |-> $past(vmode)) else $error("device drove outside verify");
  a_read_float: assert property (
    $rose(upper_port[7]) |=> dev_data_oe == 8'h00) else $error("data port not released");
  c_program: cover property ($fell(program_pulse_strobe_n) && !upper_port[6]);
  c_lock: cover property ($fell(program_pulse_strobe_n) && upper_port[6]);
  c_verify: cover property (vmode && dev_data_oe != 8'h00);
endmodule

// >>> verification/tb_top.sv
// bench: programmer and device joined, driven through the register port
`timescale 1ns/10ps
module tb_top;
  // ************************************************************
  // stimulus and instances
  // ************************************************************
  localparam logic [1:0] PRG = eprom_port_pkg::CMD_PROGRAM;
  localparam logic [1:0] VFY = eprom_port_pkg::CMD_VERIFY;
  localparam logic [1:0] LCK = eprom_port_pkg::CMD_LOCK;
  logic clock = 1'b0; // 20 MHz
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic uv_erase = 1'b0;
  logic [15:0] reg_rdata;
  logic erase_busy;
  logic secured;
  logic external_fetch_allowed;
  int fail_count = 0;
  int checked = 0;
  eprom_port_if pins_if();
  always #25 clock = ~clock;
  // short pulse keeps each program command near 1200 cycles
  eprom_programmer #(.PULSE_CYCLES(50)) eprom_programmer_inst (.clock(clock),
    .reset_n(reset_n), .pins(pins_if), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  eprom_target eprom_target_inst (.clock(clock), .reset_n(reset_n), .pins(pins_if),
    .uv_erase(uv_erase), .erase_busy(erase_busy), .secured(secured),
    .external_fetch_allowed(external_fetch_allowed));
  eprom_port_assertions eprom_port_assertions_inst (.clock(clock), .reset_n(reset_n),
    .reset_pin(pins_if.reset_pin), .program_fetch_strobe_n(pins_if.program_fetch_strobe_n),
    .program_pulse_strobe_n(pins_if.program_pulse_strobe_n),
    .external_access_hv_pin(pins_if.external_access_hv_pin),
    .addr_low_port(pins_if.addr_low_port), .upper_port(pins_if.upper_port),
    .data_port(pins_if.data_port), .dev_data_oe(pins_if.dev_data_oe));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // a wait that used up its bound ends the run
  task automatic limit(input int n);
    if (n >= 5000) begin
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // one command; polls status until idle with done set
  task automatic run(input logic [1:0] c, input logic [11:0] a, input logic [7:0] b,
      output logic [15:0] st);
    int n;
    wr(eprom_port_pkg::REG_TARGET, {4'h0, a});
    wr(eprom_port_pkg::REG_BYTE, {8'h00, b});
    wr(eprom_port_pkg::REG_COMMAND, {14'h0000, c});
    for (n = 0; n < 5000; n++) begin
      rd(eprom_port_pkg::REG_STATUS, st);
      if (st[1:0] === 2'h2) break;
    end
    limit(n);
  endtask
  // full erasure sweep; lock must be clear afterwards
  task automatic erase();
    int n;
    @(posedge clock);
    uv_erase <= 1'b1;
    @(posedge clock);
    uv_erase <= 1'b0;
    for (n = 0; n < 5000; n++) begin
      @(negedge clock);
      if (erase_busy === 1'b0) break;
    end
    limit(n);
    chk({14'h0000, secured, external_fetch_allowed}, 16'h0001);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_fresh();
    logic [15:0] st;
    erase();
    run(VFY, 12'hFFF, 8'h00, st);
    chk(st & 16'hFF00, 16'hFF00);
    rd(4'hF, st);
    chk(st, 16'h0000);
  endtask
  // second write only clears bits, so the readback differs
  task automatic s_program();
    logic [15:0] st;
    run(PRG, 12'h123, 8'hA5, st);
    chk(st & 16'hFF04, 16'hA500);
    run(PRG, 12'h123, 8'h3C, st);
    chk(st & 16'hFF04, 16'h2404);
    run(VFY, 12'h123, 8'h00, st);
    chk(st & 16'hFF00, 16'h2400);
    run(VFY, 12'h023, 8'h00, st);
    chk(st & 16'hFF00, 16'hFF00);
    rd(eprom_port_pkg::REG_TARGET, st);
    chk(st, 16'h0023);
  endtask
  // locked device: no readout, pulses ignored
  task automatic s_lock();
    logic [15:0] st;
    run(LCK, 12'h000, 8'h00, st);
    chk({14'h0000, secured, external_fetch_allowed}, 16'h0002);
    run(VFY, 12'h123, 8'h00, st);
    chk(st & 16'hFF00, 16'hFF00);
    run(PRG, 12'h456, 8'h00, st);
    chk(st & 16'hFF04, 16'hFF04);
  endtask
  task automatic s_reerase();
    logic [15:0] st;
    erase();
    run(VFY, 12'h123, 8'h00, st);
    chk(st & 16'hFF00, 16'hFF00);
    run(PRG, 12'h456, 8'h5A, st);
    chk(st & 16'hFF04, 16'h5A00);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    s_fresh();
    s_program();
    s_lock();
    s_reerase();
    summarize();
  end
endmodule
